// File: shared/dccp_map.svh
`ifndef DCCP_MAP_SVH
`define DCCP_MAP_SVH

// ------------------------------------------------------------------
// Field widths and codes
// ------------------------------------------------------------------
`define DCCP_CNT_W        16
`define DCCP_MODE_W       3
`define DCCP_TIMER_NUM    2
`define DCCP_MODE_CONT    3'h5
`define DCCP_MODE_OFF     3'h0

// ------------------------------------------------------------------
// Reset values and counter increment
// ------------------------------------------------------------------
`define DCCP_CNT_ZERO     16'h0000
`define DCCP_CNT_ONE      16'h0001
`define DCCP_PIN_RST      1'h0
`define DCCP_FLAG_RST     1'h0

`endif

// File: shared/dccp_pkg.sv
`include "dccp_map.svh"

package dccp_pkg;

    typedef logic [`DCCP_CNT_W-1:0] dccp_count_t;

    // One external timer as the channel sees it
    typedef struct packed {
        logic        run;
        dccp_count_t period;
    } dccp_timer_t;

    // Compare values written by software
    typedef struct packed {
        dccp_count_t primary;
        dccp_count_t secondary;
    } dccp_compare_t;

    typedef enum logic [1:0] {
        DCCP_IDLE,
        DCCP_WAIT_RISE,
        DCCP_WAIT_FALL
    } dccp_state_t;

endpackage

// File: rtl/dccp_time_base.sv
`timescale 1ns/100ps
`include "dccp_map.svh"

module dccp_time_base
(
    input  wire logic                clk_sys,
    input  wire logic                reset_n,
    input  wire dccp_pkg::dccp_timer_t timerCfg,
    output logic [`DCCP_CNT_W-1:0]   timerCountValue,
    output logic                     periodMatch
);

    logic [`DCCP_CNT_W-1:0] count_q;

    assign timerCountValue = count_q;
    assign periodMatch     = timerCfg.run && (count_q == timerCfg.period);

    // ------------------------------------------------------------------
    // Up counter, wraps to zero the clock after the period value
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            count_q <= `DCCP_CNT_ZERO;
        end
        else if (periodMatch)
        begin
            count_q <= `DCCP_CNT_ZERO;
        end
        else if (timerCfg.run)
        begin
            count_q <= count_q + `DCCP_CNT_ONE;
        end
    end

endmodule // dccp_time_base

// File: rtl/dccp_channel.sv
`timescale 1ns/100ps
`include "dccp_map.svh"

module dccp_channel
(
    input  wire logic                   clk_sys,
    input  wire logic                   reset_n,
    input  wire logic                   moduleOn,
    input  wire logic [`DCCP_MODE_W-1:0] pulseModeSelect,
    input  wire logic                   timeBaseSelect,
    input  wire dccp_pkg::dccp_timer_t  timerCfg0,
    input  wire dccp_pkg::dccp_timer_t  timerCfg1,
    input  wire dccp_pkg::dccp_compare_t compareCfg,
    input  wire logic                   flagClear,
    output logic                        compareOutputPin,
    output logic                        compareEventFlag,
    output logic [`DCCP_CNT_W-1:0]      timerCountValue,
    output logic                        channelActive
);

    // ------------------------------------------------------------------
    // Time bases
    // ------------------------------------------------------------------
    dccp_pkg::dccp_timer_t  timerCfg [`DCCP_TIMER_NUM];
    logic [`DCCP_CNT_W-1:0] timerCount [`DCCP_TIMER_NUM];
    logic                   timerWrap [`DCCP_TIMER_NUM];

    assign timerCfg[0] = timerCfg0;
    assign timerCfg[1] = timerCfg1;

    genvar gi;
    generate
        for (gi = 0; gi < `DCCP_TIMER_NUM; gi++)
        begin : gTimer
            dccp_time_base u_dccp_time_base
            (
                .clk_sys         (clk_sys),
                .reset_n         (reset_n),
                .timerCfg        (timerCfg[gi]),
                .timerCountValue (timerCount[gi]),
                .periodMatch     (timerWrap[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // Compare qualification
    // ------------------------------------------------------------------
    logic [`DCCP_CNT_W-1:0] selCount;
    logic [`DCCP_CNT_W-1:0] lastCount_q;
    logic                   modeActive;
    logic                   active_q;
    logic                   entering;
    logic                   countMoved;
    logic                   primaryMatch;
    logic                   secondaryMatch;
    dccp_pkg::dccp_state_t  state_q;
    dccp_pkg::dccp_state_t  state_d;
    logic                   pin_q;
    logic                   pin_d;
    logic                   fallEvent;
    logic                   flag_q;

    assign selCount   = timeBaseSelect ? timerCount[1] : timerCount[0];
    assign modeActive = moduleOn
                        && (pulseModeSelect == `DCCP_MODE_CONT);
    assign entering   = modeActive && !active_q;

    // A compare counts only once the time base has moved since the last
    // clock; the count standing at entry is never taken as a match, so a
    // primary of zero with the timer at zero waits a full period.
    assign countMoved     = (selCount != lastCount_q);
    assign primaryMatch   = countMoved
                            && (selCount == compareCfg.primary);
    assign secondaryMatch = countMoved
                            && (selCount == compareCfg.secondary);

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            lastCount_q <= `DCCP_CNT_ZERO;
        end
        else
        begin
            lastCount_q <= selCount;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            active_q <= 1'b0;
        end
        else
        begin
            active_q <= modeActive;
        end
    end

    // ------------------------------------------------------------------
    // Pulse sequencer
    // ------------------------------------------------------------------
    always_comb
    begin
        state_d   = state_q;
        pin_d     = pin_q;
        fallEvent = 1'b0;
        if (!modeActive)
        begin
            state_d = dccp_pkg::DCCP_IDLE;
            pin_d   = `DCCP_PIN_RST;
        end
        else if (entering)
        begin
            state_d = dccp_pkg::DCCP_WAIT_RISE;
            pin_d   = `DCCP_PIN_RST;
        end
        else
        begin
            case (state_q)
                dccp_pkg::DCCP_WAIT_RISE:
                begin
                    if (primaryMatch)
                    begin
                        state_d = dccp_pkg::DCCP_WAIT_FALL;
                        pin_d   = 1'b1;
                    end
                end
                dccp_pkg::DCCP_WAIT_FALL:
                begin
                    // Primary matches are ignored while high, so a
                    // secondary at or below the primary falls next period
                    if (secondaryMatch)
                    begin
                        state_d   = dccp_pkg::DCCP_WAIT_RISE;
                        pin_d     = 1'b0;
                        fallEvent = 1'b1;
                    end
                end
                default:
                begin
                    state_d = dccp_pkg::DCCP_WAIT_RISE;
                    pin_d   = `DCCP_PIN_RST;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_q <= dccp_pkg::DCCP_IDLE;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pin_q <= `DCCP_PIN_RST;
        end
        else
        begin
            pin_q <= pin_d;
        end
    end

    // ------------------------------------------------------------------
    // Event flag
    // ------------------------------------------------------------------
    // Set wins over a clear in the same clock so no fall is lost
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            flag_q <= `DCCP_FLAG_RST;
        end
        else if (fallEvent)
        begin
            flag_q <= 1'b1;
        end
        else if (flagClear)
        begin
            flag_q <= 1'b0;
        end
    end

    assign compareOutputPin = pin_q;
    assign compareEventFlag = flag_q;
    assign timerCountValue  = selCount;
    assign channelActive    = active_q;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!reset_n);

    a_rise_after_match: assert property (
        (modeActive && !entering && state_q == dccp_pkg::DCCP_WAIT_RISE
         && primaryMatch) |=> compareOutputPin)
        else $error("Pin did not rise after primary match");

    a_fall_after_match: assert property (
        (modeActive && !entering && state_q == dccp_pkg::DCCP_WAIT_FALL
         && secondaryMatch) |=> !compareOutputPin)
        else $error("Pin did not fall after secondary match");

    a_entry_low: assert property (
        entering |=> !compareOutputPin)
        else $error("Pin not low on mode entry");

    a_off_low: assert property (
        !modeActive |=> !compareOutputPin && state_q == dccp_pkg::DCCP_IDLE)
        else $error("Pin not low with mode off");

    a_flag_on_fall: assert property (
        ($fell(compareOutputPin) && $past(modeActive)) |-> compareEventFlag)
        else $error("Fall without event flag");

    a_flag_sticky: assert property (
        (compareEventFlag && !flagClear) |=> compareEventFlag)
        else $error("Event flag dropped without clear");

    a_flag_cause: assert property (
        $rose(compareEventFlag) |-> $fell(compareOutputPin))
        else $error("Flag raised without a falling edge");

    a_rise_cause: assert property (
        $rose(compareOutputPin)
        |-> $past(selCount) == $past(compareCfg.primary))
        else $error("Pin rose without primary match");

    a_hold_high: assert property (
        (compareOutputPin && modeActive && !secondaryMatch)
        |=> compareOutputPin)
        else $error("Pin fell without secondary match");

    a_wrap_zero: assert property (
        (timerWrap[0]) |=> timerCount[0] == `DCCP_CNT_ZERO)
        else $error("Time base did not wrap to zero");

    a_second_wrap_zero: assert property (
        timerWrap[1] |=> timerCount[1] == `DCCP_CNT_ZERO)
        else $error("Second time base did not wrap to zero");

    c_full_pulse: cover property (
        $rose(compareOutputPin) ##[1:300] $fell(compareOutputPin));

    c_one_low: cover property (
        $fell(compareOutputPin) ##1 $rose(compareOutputPin));

    c_flag_clear: cover property (
        compareEventFlag && flagClear);

    c_mode_exit: cover property (
        compareOutputPin && !modeActive);

endmodule // dccp_channel

// File: tb/dccp_load.sv
`timescale 1ns/100ps

// ----------------------------------------
// Load on the pin: counts rising edges
// ----------------------------------------
module dccp_load
(
    input  wire logic        clk_sys,
    input  wire logic        reset_n,
    input  wire logic        loadIn,
    output logic [15:0]      riseCount
);
    logic lastQ;

    always_ff @(posedge clk_sys or negedge reset_n)
        if (!reset_n)
        begin
            lastQ     <= 1'h0;
            riseCount <= 16'h0000;
        end
        else
        begin
            lastQ <= loadIn;
            if (loadIn && !lastQ)
                riseCount <= riseCount + 16'h0001;
        end
endmodule // dccp_load

// File: tb/test_dccp_channel.sv
`timescale 1ns/100ps
`include "dccp_map.svh"

module test_dccp_channel;
    logic                    clk_sys, reset_n, moduleOn, timeBaseSelect;
    logic                    flagClear, pin, flag, act, mPin, mFlag, mAct;
    logic [`DCCP_MODE_W-1:0] pulseModeSelect;
    dccp_pkg::dccp_timer_t   t0, t1;
    dccp_pkg::dccp_compare_t cmp;
    logic [15:0]             cnt, mC0, mC1, mPrev, rises;
    logic [34:0]             e;
    logic [34:0]             q[$];
    int                      err_count, n_checks, mRise, seed, k, rr, rp;

    dccp_channel u_dccp_channel (.clk_sys(clk_sys), .reset_n(reset_n),
        .moduleOn(moduleOn), .pulseModeSelect(pulseModeSelect),
        .timeBaseSelect(timeBaseSelect), .timerCfg0(t0), .timerCfg1(t1),
        .compareCfg(cmp), .flagClear(flagClear), .compareOutputPin(pin),
        .compareEventFlag(flag), .timerCountValue(cnt), .channelActive(act));
    dccp_load u_dccp_load (.clk_sys(clk_sys), .reset_n(reset_n),
        .loadIn(pin), .riseCount(rises));

    // ----------------------------------------
    // Checking
    // ----------------------------------------
    task check(input string what, input logic [15:0] seen, exp);
        n_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("BAD %s exp %h seen %h", what, exp, seen);
        end
    endtask

    task conclude;
        if (err_count == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Reference of the channel, one step per sampled edge
    task model;
        logic [15:0] c;
        logic        on, hp, hs;
        c = timeBaseSelect ? mC1 : mC0;
        on = moduleOn && pulseModeSelect == `DCCP_MODE_CONT;
        // A match needs a moving count and a mode already running
        hp = on && mAct && c != mPrev && c == cmp.primary;
        hs = on && mAct && c != mPrev && c == cmp.secondary;
        mFlag = (mPin && hs) || (mFlag && !flagClear);
        if (on && !mPin && hp)
            mRise++;
        mPin = on && (mPin ? !hs : hp);
        mPrev = c;
        mAct = on;
        if (t0.run)
            mC0 = (mC0 == t0.period) ? 16'h0000 : mC0 + 16'h0001;
        if (t1.run)
            mC1 = (mC1 == t1.period) ? 16'h0000 : mC1 + 16'h0001;
        q.push_back({mAct, mPin, mFlag, mC0, mC1});
    endtask

    task run(input int n);
        repeat (n)
        begin
            @(posedge clk_sys);
            model();
        end
    endtask

    task cfg(input logic sel, input logic [15:0] per, p, s);
        timeBaseSelect <= sel;
        t0.period <= per;
        t1.period <= per;
        cmp <= {p, s};
    endtask

    task restart;
        pulseModeSelect <= `DCCP_MODE_OFF;
        run(2);
        pulseModeSelect <= `DCCP_MODE_CONT;
    endtask

    always @(negedge clk_sys)
        if (reset_n && q.size() > 0)
        begin
            e = q.pop_front();
            check("active", 16'(act), 16'(e[34]));
            check("pin", 16'(pin), 16'(e[33]));
            check("flag", 16'(flag), 16'(e[32]));
            check("count", cnt, timeBaseSelect ? e[15:0] : e[31:16]);
        end

    // ----------------------------------------
    // Stimulus
    // ----------------------------------------
    initial
    begin
        clk_sys = 1'h0;
        forever #10 clk_sys = ~clk_sys;
    end

    initial
    begin
        repeat (5000) @(posedge clk_sys);
        err_count++;
        conclude();
    end

    initial
    begin
        seed = 32'hA4DB;
        {reset_n, moduleOn, timeBaseSelect, flagClear} = 4'h0;
        {mPin, mFlag, mAct, mC0, mC1, mPrev} = '0;
        pulseModeSelect = `DCCP_MODE_OFF;
        {t0, t1, cmp} = '0;
        repeat (4) @(posedge clk_sys);
        reset_n <= 1'h1;
        run(2);
        t0.run <= 1'h1;
        cfg(1'h0, 16'h0005, 16'h0001, 16'h0003);
        pulseModeSelect <= `DCCP_MODE_CONT;
        moduleOn <= 1'h1;
        run(30);
        flagClear <= 1'h1;
        run(1);
        flagClear <= 1'h0;
        run(12);
        // Every mode code; only the continuous one may pulse
        for (k = 0; k < 8; k++)
        begin
            pulseModeSelect <= k[2:0];
            run(14);
        end
        moduleOn <= 1'h0;
        run(8);
        moduleOn <= 1'h1;
        run(10);
        cfg(1'h0, 16'h0005, 16'h0002, 16'h0007);
        run(20);
        cmp.secondary <= 16'h0004;
        run(14);
        // Timer 1 still stopped at zero
        cfg(1'h1, 16'h0005, 16'h0000, 16'h0003);
        restart();
        run(3);
        t1.run <= 1'h1;
        run(20);
        cfg(1'h1, 16'h0005, 16'h0000, 16'h0005);
        run(20);
        cfg(1'h0, 16'h0005, 16'h0003, 16'h0001);
        restart();
        run(20);
        cfg(1'h1, 16'h0005, 16'h0007, 16'h0003);
        restart();
        run(20);
        for (k = 0; k < 12; k++)
        begin
            // Periods only grow, so no running count sits above its period
            rr = 5 + 2 * k + {$random(seed)} % 2;
            rp = 1 + {$random(seed)} % (rr - 1);
            cfg(k[0], rr[15:0], rp[15:0],
                rp[15:0] + 16'h0001 + 16'({$random(seed)} % (rr - rp)));
            flagClear <= 1'($random(seed));
            restart();
            run(3 * rr + 5);
        end
        // Load registers the pin; let the last rise reach its count
        pulseModeSelect <= `DCCP_MODE_OFF;
        run(3);
        @(negedge clk_sys);
        check("rises", rises, mRise[15:0]);
        conclude();
    end
endmodule // test_dccp_channel
